// ===== hw/i2cpe_pkg.sv
// Purpose: Shared constants and types for the two-wire bus protocol engine
// Assumes: Core clock of 100 MHz; standard-mode bus timing
// Notes: Timing figures are in ns; cycle counts are derived from them
package i2cpe_pkg;

  localparam int I2CPE_CLK_NS = 10;
  localparam int I2CPE_T_LOW_NS = 4700;
  localparam int I2CPE_T_HIGH_NS = 4000;
  localparam int I2CPE_T_HD_STA_NS = 4000;
  // Least times round up to whole cycles
  localparam int I2CPE_LOW_CYC = (I2CPE_T_LOW_NS + I2CPE_CLK_NS - 1)
    / I2CPE_CLK_NS;
  localparam int I2CPE_HIGH_CYC = (I2CPE_T_HIGH_NS + I2CPE_CLK_NS - 1)
    / I2CPE_CLK_NS;
  localparam int I2CPE_HD_CYC = (I2CPE_T_HD_STA_NS + I2CPE_CLK_NS - 1)
    / I2CPE_CLK_NS;
  localparam int I2CPE_TMR_W = 16;

  // Long-format first byte prefix and its position
  localparam logic [4:0] I2CPE_ADDR10_PREFIX = 5'h1e;
  localparam int I2CPE_PREFIX_LSB = 3;
  localparam logic [3:0] I2CPE_ACK_SLOT = 4'h8;
  localparam logic [3:0] I2CPE_ACK_SEEN = 4'h9;
  localparam logic [3:0] I2CPE_LAST_BIT = 4'h7;

  typedef enum logic [2:0] {
    I2CPE_S_IDLE = 3'b000,
    I2CPE_S_RX = 3'b001,
    I2CPE_S_ACK = 3'b010,
    I2CPE_S_HOLD = 3'b011,
    I2CPE_S_LOAD = 3'b100,
    I2CPE_S_TX = 3'b101,
    I2CPE_S_TACK = 3'b110,
    I2CPE_S_IGN = 3'b111
  } i2cpe_sstate_t;

  typedef enum logic [1:0] {
    I2CPE_P_ADR1 = 2'b00,
    I2CPE_P_ADR2 = 2'b01,
    I2CPE_P_DATA = 2'b10
  } i2cpe_phase_t;

  typedef enum logic [3:0] {
    I2CPE_M_IDLE = 4'b0000,
    I2CPE_M_START = 4'b0001,
    I2CPE_M_LOW = 4'b0010,
    I2CPE_M_WAITH = 4'b0011,
    I2CPE_M_HIGH = 4'b0100,
    I2CPE_M_NEXT = 4'b0101,
    I2CPE_M_RS1 = 4'b0110,
    I2CPE_M_RS2 = 4'b0111,
    I2CPE_M_STOP1 = 4'b1000,
    I2CPE_M_STOP2 = 4'b1001
  } i2cpe_mstate_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_addr;
    logic rw;
  } i2cpe_rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic start;
    logic stop;
  } i2cpe_mcmd_t;

  typedef struct packed {
    logic ack;
    logic lost;
  } i2cpe_mres_t;

endpackage

// ===== hw/i2cpe_sync.sv
// Purpose: Two-stage level synchroniser into the core clock
// Assumes: Each bit is an independent level
// Notes: Only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
module i2cpe_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_r <= '1;
      q_r <= '1;
    end
    else
    begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule
`default_nettype wire

// ===== hw/i2cpe_link.sv
// Purpose: Data-line sampler clocked by the bus clock itself
// Assumes: Bus clock only moves during frames
// Notes: Each rising edge flips a toggle; the bit stays stable a full period
`timescale 1ns/1ps
`default_nettype none
module i2cpe_link (
  // Link clock and reset
  input wire logic i_scl_link_clk,
  input wire logic i_arst_n,
  // Data line
  input wire logic i_sda,
  // Toward the core domain
  output logic o_bit,
  output logic o_tog
);
  logic bit_r;
  logic tog_r;

  always_ff @(posedge i_scl_link_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bit_r <= 1'b1;
      // Matches the core synchroniser's reset level, so no false bit event
      tog_r <= 1'b1;
    end
    else
    begin
      bit_r <= i_sda;
      tog_r <= ~tog_r;
    end
  end

  assign o_bit = bit_r;
  assign o_tog = tog_r;
endmodule
`default_nettype wire

// ===== hw/i2cpe_engine.sv
// Purpose: Two-wire bus protocol engine, slave plus simple master
// Assumes: Open-drain pins with external pull-ups; standard-mode timing
// Notes: Slave listens all the time, so a lost master falls into it
// What this block does
// (RULE1) Both lines high and released mean idle
// (RULE2) Data falling while clock high is start
// (RULE3) Data rising while clock high is stop
// (RULE4) Data changes only while clock is low
// (RULE5) Master generates start and stop conditions
// (RULE6) Short address: seven bits plus direction
// (RULE7) Long address: two bytes, five-bit flag prefix
// (RULE8) Whole bytes, no limit per transfer
// (RULE9) Slave-receiver acks every received byte; here it nacks while i_rx_busy is high
// (RULE10) Master abandons transfer on missing ack
// (RULE11) Nacking slave leaves data line released
// (RULE12) Master-receiver nacks only the last byte; here the master only writes and never reads
// (RULE13) Slave-transmitter releases data on master nack
// (RULE14) Master may stop during the ack slot
// (RULE15) Slave may hold clock low; master waits
// (RULE16) Transmitter stretches always; receiver only if enabled
// (RULE17) Clock release bit low holds clock low
// (RULE18) Repeated start after ack slot is new start
// (RULE19) Driving high, seeing low loses arbitration
// (RULE20) Loser clocks only to end of byte
// (RULE21) Loser becomes slave-receiver at once
// (RULE22) Low counted from fall; high after rise
// (RULE23) Long first byte: 11110, A9, A8, write
// (RULE24) Lines synchronised and edge-detected before use
// (RULE25) Lines only pulled low or released
`timescale 1ns/1ps
`default_nettype none
module i2cpe_engine #(
  parameter int LOW_CYC = i2cpe_pkg::I2CPE_LOW_CYC,
  parameter int HIGH_CYC = i2cpe_pkg::I2CPE_HIGH_CYC,
  parameter int HD_CYC = i2cpe_pkg::I2CPE_HD_CYC
) (
  // Clocks and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_scl_link_clk,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_o,
  output logic o_scl_oe_n,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  // Slave configuration
  input wire logic [9:0] i_own_addr,
  input wire logic i_addr10_en,
  input wire logic i_rx_busy,
  input wire logic i_clock_release_bit,
  // Slave receive stream
  output logic o_rx_valid,
  output i2cpe_pkg::i2cpe_rx_t o_rx,
  // Slave transmit stream
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Master command and result
  input wire logic i_mst_valid,
  input wire i2cpe_pkg::i2cpe_mcmd_t i_mst_cmd,
  output logic o_mst_ready,
  output logic o_mst_done,
  output i2cpe_pkg::i2cpe_mres_t o_mst_res,
  // Bus status
  output logic o_bus_busy,
  output logic o_slv_active,
  output logic o_start_seen,
  output logic o_stop_seen
);
  import i2cpe_pkg::*;

  localparam int TW = I2CPE_TMR_W;
  localparam logic [TW-1:0] LOW_T = TW'(LOW_CYC);
  localparam logic [TW-1:0] HIGH_T = TW'(HIGH_CYC);
  localparam logic [TW-1:0] HD_T = TW'(HD_CYC);

  generate
    if (LOW_CYC < 2 || HIGH_CYC < 2 || HD_CYC < 2 ||
        LOW_CYC >= (1 << TW) || HIGH_CYC >= (1 << TW) ||
        HD_CYC >= (1 << TW))
    begin : g_bad_timing
      $error("i2cpe_engine: timing counts out of range");
    end
  endgenerate

  // Pin sampling and edges
  logic [1:0] pin_s;
  logic [1:0] lk_s;
  logic lk_bit;
  logic lk_tog;
  logic scl_d_r;
  logic sda_d_r;
  logic tog_d_r;
  logic bit_ev_r;
  logic busy_r;
  logic start_r;
  logic stop_r;

  i2cpe_sync #(.W(2)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_d({i_scl, i_sda}),
    .o_q(pin_s)
  );

  i2cpe_link u_link (
    .i_scl_link_clk(i_scl_link_clk),
    .i_arst_n(i_arst_n),
    .i_sda(i_sda),
    .o_bit(lk_bit),
    .o_tog(lk_tog)
  );

  // Toggle and bit cross together; the bit is read one cycle late
  i2cpe_sync #(.W(2)) u_link_sync (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_d({lk_tog, lk_bit}),
    .o_q(lk_s)
  );

  wire scl_s = pin_s[1];
  wire sda_s = pin_s[0];
  wire scl_fall = scl_d_r & ~scl_s; // RULE24
  wire start_ev = scl_d_r & scl_s & sda_d_r & ~sda_s; // RULE2 RULE18
  wire stop_ev = scl_d_r & scl_s & ~sda_d_r & sda_s; // RULE3
  wire bit_ev = lk_s[1] ^ tog_d_r;
  wire bit_val = lk_s[0];
  wire bus_idle = ~busy_r & scl_s & sda_s; // RULE1

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tog_d_r <= 1'b1;
      bit_ev_r <= 1'b0;
      busy_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tog_d_r <= lk_s[1];
      bit_ev_r <= bit_ev;
      busy_r <= start_ev | (busy_r & ~stop_ev); // RULE1
      start_r <= start_ev;
      stop_r <= stop_ev;
    end
  end

  // Slave engine
  i2cpe_sstate_t s_st_r;
  i2cpe_phase_t s_ph_r;
  logic [3:0] s_cnt_r;
  logic [7:0] s_sh_r;
  logic s_sda_r;
  logic s_scl_r;
  logic s_tx_r;
  logic hit10_r;
  logic rx_valid_r;
  i2cpe_rx_t rx_r;

  wire rw_bit = s_sh_r[0];
  wire hit7 = s_sh_r[7:1] == i_own_addr[6:0]; // RULE6
  wire hit_hi = s_sh_r[7:I2CPE_PREFIX_LSB] == I2CPE_ADDR10_PREFIX &&
    s_sh_r[2:1] == i_own_addr[9:8]; // RULE7 RULE23
  wire hit_lo = s_sh_r == i_own_addr[7:0];
  wire adr1_ok = i_addr10_en ? hit_hi & (~rw_bit | hit10_r) : hit7;
  wire ack_ok = ~i_rx_busy & (s_ph_r == I2CPE_P_DATA ? 1'b1 :
    s_ph_r == I2CPE_P_ADR2 ? hit_lo : adr1_ok);
  wire byte_done = s_cnt_r == I2CPE_ACK_SLOT && ~scl_s;
  wire next_tx = s_ph_r == I2CPE_P_ADR1 ? rw_bit : s_tx_r;
  wire next_10 = s_ph_r == I2CPE_P_ADR1 && i_addr10_en && ~rw_bit;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_st_r <= I2CPE_S_IDLE;
      s_ph_r <= I2CPE_P_ADR1;
      s_cnt_r <= 4'h0;
      s_sh_r <= 8'h00;
      s_sda_r <= 1'b0;
      s_scl_r <= 1'b0;
      s_tx_r <= 1'b0;
      hit10_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_r <= '0;
    end
    else
    begin
      rx_valid_r <= 1'b0;
      if (start_ev)
      begin
        // A repeated start restarts addressing from any state
        s_st_r <= I2CPE_S_RX; // RULE18 RULE21
        s_ph_r <= I2CPE_P_ADR1;
        s_cnt_r <= 4'h0;
        s_sda_r <= 1'b0;
        s_scl_r <= 1'b0;
        s_tx_r <= 1'b0;
      end
      else if (stop_ev)
      begin
        s_st_r <= I2CPE_S_IDLE; // RULE3
        s_sda_r <= 1'b0;
        s_scl_r <= 1'b0;
        hit10_r <= 1'b0;
      end
      else
      begin
        unique case (s_st_r)
          I2CPE_S_IDLE:
          begin
          end
          I2CPE_S_RX:
          begin
            if (bit_ev_r)
            begin
              s_sh_r <= {s_sh_r[6:0], bit_val};
              s_cnt_r <= s_cnt_r + 4'h1;
            end
            if (byte_done)
            begin
              s_cnt_r <= 4'h0;
              if (ack_ok)
              begin
                s_sda_r <= 1'b1; // RULE9
                s_st_r <= I2CPE_S_ACK;
                rx_valid_r <= 1'b1;
                rx_r <= '{data: s_sh_r,
                          is_addr: s_ph_r != I2CPE_P_DATA,
                          rw: next_tx};
                s_tx_r <= next_tx;
                s_ph_r <= next_10 ? I2CPE_P_ADR2 : I2CPE_P_DATA;
                if (s_ph_r == I2CPE_P_ADR2)
                begin
                  hit10_r <= 1'b1;
                end
              end
              else
              begin
                s_st_r <= I2CPE_S_IGN; // RULE11
              end
            end
          end
          I2CPE_S_ACK:
          begin
            if (scl_fall)
            begin
              s_sda_r <= 1'b0;
              s_cnt_r <= 4'h0;
              if (s_tx_r)
              begin
                s_scl_r <= 1'b1; // RULE16
                s_st_r <= I2CPE_S_LOAD;
              end
              else if (!i_clock_release_bit)
              begin
                s_scl_r <= 1'b1; // RULE17
                s_st_r <= I2CPE_S_HOLD;
              end
              else
              begin
                s_st_r <= I2CPE_S_RX; // RULE8
              end
            end
          end
          I2CPE_S_HOLD:
          begin
            if (i_clock_release_bit)
            begin
              s_scl_r <= 1'b0; // RULE15
              s_st_r <= I2CPE_S_RX;
            end
          end
          I2CPE_S_LOAD:
          begin
            if (i_tx_valid)
            begin
              s_sh_r <= i_tx_data;
              s_sda_r <= ~i_tx_data[7]; // RULE4
              s_scl_r <= 1'b0; // RULE15
              s_cnt_r <= 4'h0;
              s_st_r <= I2CPE_S_TX;
            end
          end
          I2CPE_S_TX:
          begin
            if (scl_fall)
            begin
              s_cnt_r <= s_cnt_r + 4'h1;
              if (s_cnt_r == I2CPE_LAST_BIT)
              begin
                s_sda_r <= 1'b0;
                s_st_r <= I2CPE_S_TACK;
              end
              else
              begin
                s_sda_r <= ~s_sh_r[6]; // RULE4
                s_sh_r <= {s_sh_r[6:0], 1'b0};
              end
            end
          end
          I2CPE_S_TACK:
          begin
            if (bit_ev_r && bit_val)
            begin
              s_st_r <= I2CPE_S_IGN; // RULE13
            end
            else if (bit_ev_r)
            begin
              s_cnt_r <= I2CPE_ACK_SEEN;
            end
            else if (s_cnt_r == I2CPE_ACK_SEEN && !scl_s)
            begin
              s_scl_r <= 1'b1; // RULE16
              s_st_r <= I2CPE_S_LOAD;
            end
          end
          I2CPE_S_IGN:
          begin
          end
        endcase
      end
    end
  end

  // Master engine
  i2cpe_mstate_t m_st_r;
  logic [TW-1:0] m_tmr_r;
  logic [3:0] m_bit_r;
  logic [7:0] m_sh_r;
  logic m_scl_r;
  logic m_sda_r;
  logic m_stop_r;
  logic m_lost_r;
  logic m_ack_r;
  logic done_r;
  i2cpe_mres_t res_r;

  assign o_mst_ready = (m_st_r == I2CPE_M_IDLE && bus_idle) ||
    m_st_r == I2CPE_M_NEXT;
  wire m_take = i_mst_valid & o_mst_ready;
  wire tmr_zero = m_tmr_r == '0;
  wire in_ack = m_bit_r == I2CPE_ACK_SLOT;
  wire lose = ~in_ack & ~m_sda_r & ~sda_s; // RULE19
  wire bit_end = (m_st_r == I2CPE_M_HIGH) & (tmr_zero | ~scl_s);
  wire ack_now = in_ack ? ~sda_s : m_ack_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      m_st_r <= I2CPE_M_IDLE;
      m_tmr_r <= '0;
      m_bit_r <= 4'h0;
      m_sh_r <= 8'h00;
      m_scl_r <= 1'b0;
      m_sda_r <= 1'b0;
      m_stop_r <= 1'b0;
      m_lost_r <= 1'b0;
      m_ack_r <= 1'b0;
      done_r <= 1'b0;
      res_r <= '0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!tmr_zero)
      begin
        m_tmr_r <= m_tmr_r - TW'(1);
      end
      unique case (m_st_r)
        I2CPE_M_IDLE:
        begin
          if (m_take)
          begin
            m_sh_r <= i_mst_cmd.data;
            m_stop_r <= i_mst_cmd.stop;
            m_lost_r <= 1'b0;
            m_sda_r <= 1'b1; // RULE5 RULE2
            m_tmr_r <= HD_T;
            m_st_r <= I2CPE_M_START;
          end
        end
        I2CPE_M_START:
        begin
          if (tmr_zero)
          begin
            m_scl_r <= 1'b1;
            m_bit_r <= 4'h0;
            m_tmr_r <= LOW_T;
            m_st_r <= I2CPE_M_LOW;
          end
        end
        I2CPE_M_LOW:
        begin
          // Data moves only while we hold the clock low
          m_sda_r <= ~in_ack & ~m_lost_r & ~m_sh_r[7]; // RULE4 RULE20
          if (tmr_zero)
          begin
            m_scl_r <= 1'b0; // RULE22
            m_st_r <= I2CPE_M_WAITH;
          end
        end
        I2CPE_M_WAITH:
        begin
          if (scl_s)
          begin
            m_tmr_r <= HIGH_T; // RULE22 RULE15
            m_st_r <= I2CPE_M_HIGH;
          end
        end
        I2CPE_M_HIGH:
        begin
          if (scl_s && lose)
          begin
            m_lost_r <= 1'b1; // RULE19
          end
          if (scl_s && in_ack)
          begin
            m_ack_r <= ~sda_s;
          end
          if (bit_end)
          begin
            // An early fall by a peer restarts our low count
            m_tmr_r <= LOW_T; // RULE22
            m_sh_r <= {m_sh_r[6:0], 1'b0};
            m_bit_r <= m_bit_r + 4'h1;
            m_scl_r <= 1'b1;
            m_st_r <= I2CPE_M_LOW;
            if (in_ack)
            begin
              done_r <= 1'b1;
              res_r <= '{ack: ack_now, lost: m_lost_r};
              m_sda_r <= 1'b0;
              if (m_lost_r)
              begin
                m_scl_r <= 1'b0; // RULE20 RULE21
                m_st_r <= I2CPE_M_IDLE;
              end
              else if (m_stop_r || !ack_now)
              begin
                m_st_r <= I2CPE_M_STOP1; // RULE10
              end
              else
              begin
                m_st_r <= I2CPE_M_NEXT; // RULE8
              end
            end
          end
        end
        I2CPE_M_NEXT:
        begin
          if (m_take)
          begin
            m_sh_r <= i_mst_cmd.data;
            m_stop_r <= i_mst_cmd.stop;
            m_bit_r <= 4'h0;
            m_tmr_r <= LOW_T;
            m_st_r <= i_mst_cmd.start ? I2CPE_M_RS1 : I2CPE_M_LOW;
          end
        end
        I2CPE_M_RS1:
        begin
          if (tmr_zero)
          begin
            m_scl_r <= 1'b0;
            m_tmr_r <= HIGH_T;
            m_st_r <= I2CPE_M_RS2;
          end
        end
        I2CPE_M_RS2:
        begin
          if (!scl_s)
          begin
            m_tmr_r <= HIGH_T; // RULE15
          end
          else if (tmr_zero)
          begin
            m_sda_r <= 1'b1; // RULE18
            m_tmr_r <= HD_T;
            m_st_r <= I2CPE_M_START;
          end
        end
        I2CPE_M_STOP1:
        begin
          m_sda_r <= 1'b1;
          if (tmr_zero)
          begin
            m_scl_r <= 1'b0;
            m_tmr_r <= HIGH_T;
            m_st_r <= I2CPE_M_STOP2;
          end
        end
        I2CPE_M_STOP2:
        begin
          if (!scl_s)
          begin
            m_tmr_r <= HIGH_T; // RULE15
          end
          else if (tmr_zero)
          begin
            m_sda_r <= 1'b0; // RULE3 RULE5
            m_st_r <= I2CPE_M_IDLE;
          end
        end
        default:
        begin
          m_st_r <= I2CPE_M_IDLE;
          m_scl_r <= 1'b0;
          m_sda_r <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the level driven is always low
  assign o_scl_o = 1'b0; // RULE25
  assign o_sda_o = 1'b0; // RULE25
  assign o_scl_oe_n = ~(m_scl_r | s_scl_r); // RULE22
  assign o_sda_oe_n = ~(m_sda_r | s_sda_r);
  assign o_rx_valid = rx_valid_r;
  assign o_rx = rx_r;
  assign o_tx_ready = s_st_r == I2CPE_S_LOAD;
  assign o_mst_done = done_r;
  assign o_mst_res = res_r;
  assign o_bus_busy = busy_r;
  assign o_slv_active = s_st_r != I2CPE_S_IDLE && s_st_r != I2CPE_S_IGN;
  assign o_start_seen = start_r;
  assign o_stop_seen = stop_r;
endmodule
`default_nettype wire

// ===== tb/i2cpe_engine_sva.sv
// Purpose: Port-level protocol checks on the two-wire bus engine
// Assumes: Pins are resolved wire levels; all checks on the core clock
// Notes: Detection windows allow for the two-stage input synchroniser
`timescale 1ns/1ps
`default_nettype none
module i2cpe_engine_chk (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl_o,
  input wire logic o_sda_o,
  input wire logic o_scl_oe_n,
  input wire logic o_sda_oe_n,
  // Status
  input wire logic o_rx_valid,
  input wire logic o_tx_ready,
  input wire logic o_bus_busy,
  input wire logic o_start_seen,
  input wire logic o_stop_seen
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_start;
    $fell(i_sda) && i_scl ##1 i_scl [*2];
  endsequence
  sequence s_stop;
    $rose(i_sda) && i_scl ##1 i_scl [*2];
  endsequence
  property p_od;
    o_scl_o == 1'b0 && o_sda_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_start;
    s_start |-> ##[0:4] o_start_seen;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop;
    s_stop |-> ##[0:4] o_stop_seen;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_busy;
    o_start_seen |-> ##[0:1] o_bus_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");
  property p_idle;
    o_stop_seen |-> ##[0:1] !o_bus_busy;
  endproperty
  a_idle: assert property (p_idle) else $error("busy not cleared");
  property p_ack;
    o_rx_valid |-> !o_sda_oe_n;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack on byte");
  // Ack must hold for eight cycles after the valid pulse, not just one cycle
  property p_ack_hold;
    o_rx_valid |=> (!o_sda_oe_n) [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped");
  property p_txs;
    o_tx_ready |-> !o_scl_oe_n;
  endproperty
  a_txs: assert property (p_txs) else $error("tx wait unstretched");
endmodule
bind i2cpe_engine i2cpe_engine_chk u_chk (
  .i_core_clk, .i_arst_n, .i_scl, .i_sda, .o_scl_o, .o_sda_o,
  .o_scl_oe_n, .o_sda_oe_n, .o_rx_valid, .o_tx_ready, .o_bus_busy,
  .o_start_seen, .o_stop_seen
);
`default_nettype wire

// ===== tb/i2cpe_mst_bfm.sv
// Purpose: Behavioural bus master standing on the far side of the pins
// Assumes: Open-drain outputs, 1 = released; pull-ups in the bench
// Notes: Waits on a held clock are bounded; overruns are counted in to
`timescale 1ns/1ps
`default_nettype none
module i2cpe_mst_bfm #(
  parameter int H = 320
) (
  // Wire levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Open-drain controls
  output logic o_scl_rel,
  output logic o_sda_rel
);
  int to;
  initial
  begin
    to = 0;
    o_scl_rel = 1'b1;
    o_sda_rel = 1'b1;
  end
  // High time is counted only once the wired line really rose
  task automatic clk_hi();
    int n;
    o_scl_rel = 1'b1;
    n = 0;
    while (i_scl !== 1'b1 && n < 3000)
    begin
      #10;
      n++;
    end
    if (i_scl !== 1'b1)
      to++;
    #H;
  endtask
  task automatic bitx(input logic b, output logic r);
    #(H/2);
    o_sda_rel = b;
    #(H/2);
    clk_hi();
    r = i_sda;
    o_scl_rel = 1'b0;
  endtask
  task automatic start();
    #(H/2);
    o_sda_rel = 1'b1;
    #(H/2);
    clk_hi();
    o_sda_rel = 1'b0;
    #H;
    o_scl_rel = 1'b0;
  endtask
  task automatic stop();
    #(H/2);
    o_sda_rel = 1'b0;
    #(H/2);
    clk_hi();
    o_sda_rel = 1'b1;
    #H;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~ack, r);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_i2cpe_engine.sv
// Purpose: Self-checking bench for the two-wire bus engine
// Assumes: Link clock is the resolved clock wire; short master timing
// Notes: Master bit time is far slower than the core sync delay
`timescale 1ns/1ps
`default_nettype none
module tb_i2cpe_engine;
  import i2cpe_pkg::*;
  logic clk = 1'b0;
  logic rst_n, en10, rxb, relb, tx_v, mv, m_scl, m_sda;
  logic [9:0] own;
  logic [7:0] txb [4];
  int ti, num_errors, n_checks;
  i2cpe_mcmd_t mc;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, rx_v, tx_rdy, m_rdy, m_done;
  logic bus_busy, slv_act;
  i2cpe_rx_t rx;
  i2cpe_mres_t m_res;
  i2cpe_rx_t rxq[$];
  wire scl;
  wire sda;
  // Wired-AND with pull-ups
  assign scl = (scl_oe_n | scl_o) & m_scl;
  assign sda = (sda_oe_n | sda_o) & m_sda;
  always #5 clk = ~clk;
  i2cpe_engine #(.LOW_CYC(8), .HIGH_CYC(8), .HD_CYC(8)) dut (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_scl_link_clk(scl),
    .i_scl(scl), .i_sda(sda), .o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_own_addr(own),
    .i_addr10_en(en10), .i_rx_busy(rxb), .i_clock_release_bit(relb),
    .o_rx_valid(rx_v), .o_rx(rx), .i_tx_valid(tx_v),
    .i_tx_data(txb[ti[1:0]]), .o_tx_ready(tx_rdy), .i_mst_valid(mv),
    .i_mst_cmd(mc), .o_mst_ready(m_rdy), .o_mst_done(m_done),
    .o_mst_res(m_res), .o_bus_busy(bus_busy), .o_slv_active(slv_act),
    .o_start_seen(), .o_stop_seen());
  i2cpe_mst_bfm m (.i_scl(scl), .i_sda(sda), .o_scl_rel(m_scl),
    .o_sda_rel(m_sda));
  always @(posedge clk)
    if (rx_v === 1'b1)
      rxq.push_back(rx);
  // Byte source for the slave transmitter
  always @(negedge clk)
    if (tx_v && tx_rdy !== 1'b1)
    begin
      tx_v = 1'b0;
      ti++;
    end
    else if (!tx_v && tx_rdy === 1'b1)
      tx_v = 1'b1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic mchk();
    if (m.to != 0)
    begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic t_wr7();
    logic a;
    int n0;
    n0 = rxq.size();
    m.start();
    m.wr_byte({own[6:0], 1'b0}, a);
    chk(a, 1);
    #1000;
    chk(scl_oe_n, 1);
    m.wr_byte(8'h00, a);
    chk(a, 1);
    m.wr_byte(8'hff, a);
    chk(a, 1);
    m.stop();
    chk(bus_busy, 0);
    chk(slv_act, 0);
    chk(rxq.size() - n0, 3);
    chk({rxq[n0].is_addr, rxq[n0].rw}, 2'b10);
    chk(rxq[$].data, 8'hff);
    mchk();
  endtask
  task automatic t_nack();
    logic a;
    int n0;
    n0 = rxq.size();
    @(negedge clk);
    rxb = 1'b1;
    m.start();
    m.wr_byte({own[6:0], 1'b0}, a);
    chk(a, 0);
    chk(sda, 1);
    m.stop();
    @(negedge clk);
    rxb = 1'b0;
    m.start();
    m.wr_byte({own[6:0] ^ 7'h01, 1'b0}, a);
    chk(a, 0);
    m.stop();
    chk(rxq.size(), n0);
    mchk();
  endtask
  task automatic t_str();
    logic a;
    @(negedge clk);
    relb = 1'b0;
    m.start();
    m.wr_byte({own[6:0], 1'b0}, a);
    chk(a, 1);
    #2000;
    chk(scl_oe_n, 0);
    chk(slv_act, 1);
    @(negedge clk);
    relb = 1'b1;
    m.wr_byte(8'h5c, a);
    chk(a, 1);
    m.stop();
    chk(rxq[$].data, 8'h5c);
    mchk();
  endtask
  task automatic t_10b();
    logic a;
    logic [7:0] d;
    int t0;
    @(negedge clk);
    en10 = 1'b1;
    own = 10'h2a5;
    m.start();
    m.wr_byte({5'b11110, own[9:8], 1'b0}, a);
    chk(a, 1);
    m.wr_byte(own[7:0], a);
    chk(a, 1);
    m.wr_byte(8'h3c, a);
    chk(a, 1);
    chk({rxq[$].data, rxq[$].is_addr}, {8'h3c, 1'b0});
    t0 = ti;
    m.start();
    m.wr_byte({5'b11110, own[9:8], 1'b1}, a);
    chk(a, 1);
    m.rd_byte(1'b1, d);
    chk(d, txb[t0 % 4]);
    m.rd_byte(1'b0, d);
    chk(d, txb[(t0 + 1) % 4]);
    chk(sda, 1);
    m.stop();
    @(negedge clk);
    en10 = 1'b0;
    own = 10'h052;
    mchk();
  endtask
  task automatic t_mst();
    int n;
    n = 0;
    while (m_rdy !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    mc = '{data: {own[6:0], 1'b0}, start: 1'b1, stop: 1'b1};
    mv = 1'b1;
    @(negedge clk);
    mv = 1'b0;
    n = 0;
    while (m_done !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    chk(m_done, 1);
    chk({m_res.ack, m_res.lost}, 2'b10);
    n = 0;
    while (bus_busy !== 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk(bus_busy, 0);
    chk({rxq[$].data, rxq[$].is_addr}, {own[6:0], 1'b0, 1'b1});
  endtask
  initial
  begin
    rst_n = 1'b0;
    own = 10'h052;
    {en10, rxb, tx_v, mv} = 4'h0;
    relb = 1'b1;
    mc = '0;
    ti = 0;
    txb = '{8'h5a, 8'hc3, 8'h96, 8'h21};
    repeat (6) @(posedge clk);
    chk({scl_oe_n, sda_oe_n, bus_busy}, 3'b110);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_wr7();
    t_nack();
    t_str();
    t_10b();
    t_mst();
    summarize();
  end
endmodule
`default_nettype wire
